// File: hw/event_input_function_select.sv
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "event_sel_consts.svh"
module event_input_function_select
   import event_sel_pkg::*;
#(
   parameter int SP_W = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Event contact, external
   input  wire logic        event_i,
   // Raw alarm conditions from alarm logic
   input  wire logic        alarm1_cond_i,
   input  wire logic        alarm2_cond_i,
   // Tuner result write
   input  wire logic        tune_done_i,
   input  wire logic [31:0] tune_gain_i,
   // Set point feed from ramp or remote source
   input  wire logic [SP_W-1:0] source_sp_i,
   // Control outputs
   output logic [SP_W-1:0]  active_sp_o,
   output logic [31:0]      active_gain_o,
   output logic             alarm1_o,
   output logic             alarm2_o,
   output logic             out1_inhibit_o,
   output logic             out2_inhibit_o,
   output logic             param_lock_o
);

   // Elaboration check: set points must fit the 32-bit bus word
   if (SP_W < 2 || SP_W > 32) begin
      $error("SP_W out of range");
   end

   // Synchroniser and edge state
   logic       sync1_ff;                 // First stage, read only by sync2_ff
   logic       sync2_ff;                 // Stable event level
   logic       evt_prev_ff;              // Previous level for edges
   logic       nxt_sync1;
   logic       nxt_sync2;
   logic       nxt_evt_prev;
   // Registers
   logic [3:0]      fn_ff;               // Event function select
   logic            fmt_ff;              // 1 = offset format
   logic [2:0]      mode_ff;             // Set point source mode
   logic [SP_W-1:0] prim_ff;             // Primary setpoint
   logic [SP_W-1:0] alt_ff;              // Stored alternate setpoint
   logic [31:0]     gain1_ff;            // First gain set
   logic [31:0]     gain2_ff;            // Second gain set
   logic [3:0]      nxt_fn;
   logic            nxt_fmt;
   logic [2:0]      nxt_mode;
   logic [SP_W-1:0] nxt_prim;
   logic [SP_W-1:0] nxt_alt;
   logic [31:0]     nxt_gain1;
   logic [31:0]     nxt_gain2;
   // Outputs and alarm latches
   logic            alarm1_ff;
   logic            alarm2_ff;
   logic [SP_W-1:0] sp_ff;
   logic [31:0]     gain_ff;
   logic            inh1_ff;
   logic            inh2_ff;
   logic            lock_ff;
   logic            nxt_alarm1;
   logic            nxt_alarm2;
   logic [SP_W-1:0] nxt_sp;
   logic [31:0]     nxt_gain;
   logic            nxt_inh1;
   logic            nxt_inh2;
   logic            nxt_lock;
   // Bus
   bus_state_t      bus_ff;
   bus_state_t      nxt_bus;
   logic [31:0]     rdat_ff;
   logic [31:0]     nxt_rdat;
   // Decoded function intent
   logic            use_alt;
   logic            use_g2;
   logic            clr1;
   logic            clr2;
   logic            inh1;
   logic            inh2;
   logic            lck;
   logic            alt_ok;
   logic            evt;
   logic            evt_fall;
   logic [SP_W-1:0] alt_sp;
   logic            wr_take;

   // Two-flop synchroniser plus release edge detector
   always_comb begin
      nxt_sync1    = event_i;            // [R16]
      nxt_sync2    = sync1_ff;           // [R16]
      nxt_evt_prev = sync2_ff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_ff    <= 1'b0;
         sync2_ff    <= 1'b0;
         evt_prev_ff <= 1'b0;
      end else begin
         sync1_ff    <= nxt_sync1;
         sync2_ff    <= nxt_sync2;
         evt_prev_ff <= nxt_evt_prev;
      end
   end

   assign evt      = sync2_ff;
   assign evt_fall = evt_prev_ff & ~sync2_ff;

   // Function decode; set point functions gated by source mode
   always_comb begin
      alt_ok = (mode_ff == MODE_DUAL) || (mode_ff == MODE_MIN_RAMP)
               || (mode_ff == MODE_HR_RAMP);                         // [R14]
      use_alt = 1'b0;
      use_g2  = 1'b0;
      clr1    = 1'b0;
      clr2    = 1'b0;
      inh1    = 1'b0;
      inh2    = 1'b0;
      lck     = 1'b0;
      case (fn_ff)
         FN_ALT_SP:   use_alt = alt_ok;                              // [R2] [R14]
         FN_GAIN2:    use_g2 = 1'b1;                                 // [R3]
         FN_COMBINED: begin
            use_alt = alt_ok;                                        // [R4] [R14]
            use_g2  = 1'b1;                                          // [R4]
         end
         FN_CLR_A1:   clr1 = 1'b1;                                   // [R6]
         FN_CLR_A2:   clr2 = 1'b1;                                   // [R6]
         FN_CLR_BOTH: begin
            clr1 = 1'b1;                                             // [R7]
            clr2 = 1'b1;                                             // [R7]
         end
         FN_INH_O1:   inh1 = 1'b1;                                   // [R8]
         FN_INH_O2:   inh2 = 1'b1;                                   // [R8]
         FN_INH_BOTH: begin
            inh1 = 1'b1;                                             // [R9]
            inh2 = 1'b1;                                             // [R9]
         end
         FN_LOCK:     lck = 1'b1;                                    // [R11]
         default:     use_alt = 1'b0;                                // Unused codes act as none [R15] [R1]
      endcase
   end

   // Second setpoint: absolute or offset from primary
   assign alt_sp = fmt_ff ? SP_W'(prim_ff + alt_ff) : alt_ff;        // [R12] [R13]

   // Control outputs next values
   always_comb begin
      // Source mode picks primary or external feed when not switched
      nxt_sp = (mode_ff == MODE_SINGLE || mode_ff == MODE_DUAL) ? prim_ff : source_sp_i; // [R1]
      if (evt && use_alt) begin
         nxt_sp = alt_sp;                                            // [R2] [R4]
      end
      nxt_gain = (evt && use_g2) ? gain2_ff : gain1_ff;              // [R1] [R3] [R4]
      nxt_inh1 = evt & inh1;                                         // [R8] [R9] [R10]
      nxt_inh2 = evt & inh2;                                         // [R8] [R9] [R10]
      nxt_lock = evt & lck;                                          // [R11]
      // Alarm held clear while event active; retrigger on release
      nxt_alarm1 = alarm1_ff | alarm1_cond_i;
      if (evt && clr1) begin
         nxt_alarm1 = 1'b0;                                          // [R6] [R7]
      end else if (evt_fall && clr1) begin
         nxt_alarm1 = alarm1_cond_i;                                 // [R6] [R7]
      end
      nxt_alarm2 = alarm2_ff | alarm2_cond_i;
      if (evt && clr2) begin
         nxt_alarm2 = 1'b0;                                          // [R6] [R7]
      end else if (evt_fall && clr2) begin
         nxt_alarm2 = alarm2_cond_i;                                 // [R6] [R7]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_ff     <= '0;
         gain_ff   <= `GAIN_RESET;
         inh1_ff   <= 1'b0;
         inh2_ff   <= 1'b0;
         lock_ff   <= 1'b0;
         alarm1_ff <= 1'b0;
         alarm2_ff <= 1'b0;
      end else begin
         sp_ff     <= nxt_sp;
         gain_ff   <= nxt_gain;
         inh1_ff   <= nxt_inh1;
         inh2_ff   <= nxt_inh2;
         lock_ff   <= nxt_lock;
         alarm1_ff <= nxt_alarm1;
         alarm2_ff <= nxt_alarm2;
      end
   end

   // Write lands at the edge where the master samples ack, once per handshake
   assign wr_take = cyc_i & stb_i & we_i & (bus_ff == BUS_ACK);

   // Parameter registers; lock refuses bus writes, tuner still stores
   always_comb begin
      nxt_fn    = fn_ff;
      nxt_fmt   = fmt_ff;
      nxt_mode  = mode_ff;
      nxt_prim  = prim_ff;
      nxt_alt   = alt_ff;
      nxt_gain1 = gain1_ff;
      nxt_gain2 = gain2_ff;
      if (wr_take && !lock_ff) begin                                 // [R11]
         case (adr_i)
            `OFS_CTRL: begin
               if (sel_i[0]) begin
                  nxt_fn  = dat_i[`CTRL_FN_LSB +: 4];
                  nxt_fmt = dat_i[`CTRL_FMT_BIT];
               end
               if (sel_i[1]) begin
                  nxt_mode = dat_i[`CTRL_MODE_LSB +: 3];
               end
            end
            `OFS_PRIMARY: nxt_prim = dat_i[SP_W-1:0];
            `OFS_ALTERN:  nxt_alt  = dat_i[SP_W-1:0];
            `OFS_GAIN1:   nxt_gain1 = dat_i;
            `OFS_GAIN2:   nxt_gain2 = dat_i;
            default:      nxt_fn = fn_ff;
         endcase
      end
      // Tuner result goes to the gain set in use
      if (tune_done_i) begin
         if (evt && use_g2) begin
            nxt_gain2 = tune_gain_i;                                 // [R5]
         end else begin
            nxt_gain1 = tune_gain_i;                                 // [R5]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fn_ff    <= 4'h0;
         fmt_ff   <= 1'b0;
         mode_ff  <= 3'h0;
         prim_ff  <= '0;
         alt_ff   <= '0;
         gain1_ff <= `GAIN_RESET;
         gain2_ff <= `GAIN_RESET;
      end else begin
         fn_ff    <= nxt_fn;
         fmt_ff   <= nxt_fmt;
         mode_ff  <= nxt_mode;
         prim_ff  <= nxt_prim;
         alt_ff   <= nxt_alt;
         gain1_ff <= nxt_gain1;
         gain2_ff <= nxt_gain2;
      end
   end

   // Bus slave: ack one cycle after request, then drop for a cycle
   always_comb begin
      nxt_bus  = BUS_IDLE;
      nxt_rdat = rdat_ff;
      case (bus_ff)
         BUS_IDLE: begin
            if (cyc_i && stb_i) begin
               nxt_bus = BUS_ACK;
               case (adr_i)
                  `OFS_CTRL:        nxt_rdat = {21'h0, mode_ff, 3'h0, fmt_ff, fn_ff};
                  `OFS_PRIMARY:     nxt_rdat = 32'(prim_ff);
                  `OFS_ALTERN:      nxt_rdat = 32'(alt_ff);
                  `OFS_GAIN1:       nxt_rdat = gain1_ff;
                  `OFS_GAIN2:       nxt_rdat = gain2_ff;
                  `OFS_STATUS:      nxt_rdat = {26'h0, evt, lock_ff, inh2_ff, inh1_ff,
                                                alarm2_ff, alarm1_ff};
                  `OFS_ACTIVE_SP:   nxt_rdat = 32'(sp_ff);
                  `OFS_ACTIVE_GAIN: nxt_rdat = gain_ff;
                  default:          nxt_rdat = 32'h0000_0000;        // Unmapped reads zero
               endcase
            end
         end
         BUS_ACK: nxt_bus = BUS_IDLE;
         default: nxt_bus = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_ff  <= BUS_IDLE;
         rdat_ff <= 32'h0000_0000;
      end else begin
         bus_ff  <= nxt_bus;
         rdat_ff <= nxt_rdat;
      end
   end

   assign ack_o          = bus_ff[1];                                // One-hot ACK state bit
   assign dat_o          = rdat_ff;
   assign active_sp_o    = sp_ff;
   assign active_gain_o  = gain_ff;
   assign alarm1_o       = alarm1_ff;
   assign alarm2_o       = alarm2_ff;
   assign out1_inhibit_o = inh1_ff;
   assign out2_inhibit_o = inh2_ff;
   assign param_lock_o   = lock_ff;

endmodule

// File: include/event_sel_consts.svh
// Operation
// R1 - No function: ignore event, first gains, primary
// R2 - Alternate function: active event selects alternate setpoint
// R3 - Gain function: active event selects second gains
// R4 - Combined function: alternate setpoint and second gains
// R5 - Tuning results go to active gain set
// R6 - Single alarm clear; retrigger on release if present
// R7 - Dual alarm clear; each retriggers if present
// R8 - Single output inhibit while event active
// R9 - Dual inhibit disables both outputs immediately
// R10 - Inhibited outputs recover at event release
// R11 - Lock function refuses all parameter changes; the code still stores tuner results into the gain sets
// R12 - Absolute format: alternate setpoint used unchanged
// R13 - Offset format: primary plus stored alternate
// R14 - Alternate functions only in dual/ramp modes
// R15 - Four-bit select, eleven codes, others none
// R16 - Event input passes two-flop synchroniser
`ifndef EVENT_SEL_CONSTS_SVH
`define EVENT_SEL_CONSTS_SVH
// Wishbone register offsets (byte addresses)
`define OFS_CTRL     8'h00
`define OFS_PRIMARY  8'h04
`define OFS_ALTERN   8'h08
`define OFS_GAIN1    8'h0C
`define OFS_GAIN2    8'h10
`define OFS_STATUS   8'h14
`define OFS_ACTIVE_SP 8'h18
`define OFS_ACTIVE_GAIN 8'h1C
// Control register fields
`define CTRL_FN_LSB  0
`define CTRL_FMT_BIT 4
`define CTRL_MODE_LSB 8
// Gain word fields: band [15:0], integral [23:16], derivative [31:24]
`define GAIN_RESET   32'h0000_0000
`endif

// File: include/event_sel_pkg.sv
package event_sel_pkg;
   // Event function codes
   typedef enum logic [3:0] {
      FN_NONE      = 4'h0,
      FN_ALT_SP    = 4'h1,
      FN_GAIN2     = 4'h2,
      FN_COMBINED  = 4'h3,
      FN_CLR_A1    = 4'h4,
      FN_CLR_A2    = 4'h5,
      FN_CLR_BOTH  = 4'h6,
      FN_INH_O1    = 4'h7,
      FN_INH_O2    = 4'h8,
      FN_INH_BOTH  = 4'h9,
      FN_LOCK      = 4'hA
   } event_fn_t;
   // Set point source modes
   typedef enum logic [2:0] {
      MODE_SINGLE   = 3'h0,
      MODE_DUAL     = 3'h1,
      MODE_MIN_RAMP = 3'h2,
      MODE_HR_RAMP  = 3'h3,
      MODE_REMOTE1  = 3'h4,
      MODE_REMOTE2  = 3'h5
   } sp_mode_t;
   // Bus slave state, one-hot
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

// File: test/event_contact.sv
`timescale 1ns/1ps
// Timer or relay contact; it follows the bench's closure one edge later,
// switching on the clock edge like every other input of the block
module event_contact (
   input  wire logic clk_i,
   input  wire logic close_i,
   output logic      event_o
);
   initial event_o = 1'h0;
   always @(posedge clk_i) begin
      event_o <= close_i;
   end
endmodule

// File: test/event_input_function_select_tb.sv
`timescale 1ns/1ps
module event_input_function_select_tb;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, event_i;
   logic        close, a1c, a2c, tdone, al1, al2, inh1, inh2, lock;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, tgain, gain, q;
   logic [15:0] src, sp;
   int          errors, checked;
   event_input_function_select #(.SP_W(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .event_i(event_i), .alarm1_cond_i(a1c), .alarm2_cond_i(a2c), .tune_done_i(tdone),
      .tune_gain_i(tgain), .source_sp_i(src), .active_sp_o(sp), .active_gain_o(gain), .alarm1_o(al1),
      .alarm2_o(al2), .out1_inhibit_o(inh1), .out2_inhibit_o(inh2), .param_lock_o(lock));
   event_contact u_sw (.clk_i(clk_i), .close_i(close), .event_o(event_i));
   initial begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Classic single cycle; request held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= {2'h3, w};
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'h1);
      r = dat_o;
      {cyc_i, stb_i, we_i} <= 3'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d, q);
   endtask
   // Contact level, then enough edges for sync and output flop
   task automatic evt(input logic l);
      @(posedge clk_i);
      close <= l;
      repeat (5) @(posedge clk_i);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      print_verdict();
   end
   initial begin
      logic ev;
      {cyc_i, stb_i, we_i, close, a1c, a2c, tdone} = 7'h00;
      {adr_i, sel_i, dat_i, tgain} = '0;
      src = 16'h0777;
      errors = 0;
      checked = 0;
      rst_i = 1'h1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      chk(32'({al2, al1, inh2, inh1, lock}), 32'h0000_0000);
      bus(1'h0, 8'h00, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      bus(1'h0, 8'h20, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      wr(8'h04, 32'h0000_0100);
      wr(8'h08, 32'h0000_0020);
      wr(8'h0C, 32'h1111_1111);
      wr(8'h10, 32'h2222_2222);
      a1c <= 1'h1;
      a2c <= 1'h1;
      // Every code, event on then off, alarm conditions standing
      for (int f = 0; f < 16; f++) begin
         wr(8'h00, 32'h0000_0100 | 32'(f));
         for (int e = 1; e >= 0; e--) begin
            ev = e[0];
            evt(ev);
            chk(32'({al2, al1, inh2, inh1, lock}), 32'({!(ev && (f == 5 || f == 6)), !(ev && (f == 4 || f == 6)),
               ev && (f == 8 || f == 9), ev && (f == 7 || f == 9), ev && f == 10}));
            chk(32'(sp), (ev && (f == 1 || f == 3)) ? 32'h0000_0020 : 32'h0000_0100);
            chk(gain, (ev && (f == 2 || f == 3)) ? 32'h2222_2222 : 32'h1111_1111);
            if (ev && f == 10) begin
               wr(8'h04, 32'h0000_0055);
               bus(1'h0, 8'h04, 32'h0000_0000, q);
               chk(q, 32'h0000_0100);
               bus(1'h0, 8'h14, 32'h0000_0000, q);
               chk(q, 32'h0000_0033);
            end
         end
      end
      // Alternate set point only in the modes that allow it
      evt(1'h1);
      for (int m = 0; m < 6; m++) begin
         wr(8'h00, 32'(m << 8) | 32'h0000_0001);
         repeat (2) @(posedge clk_i);
         chk(32'(sp), (m >= 1 && m <= 3) ? 32'h0000_0020 : (m == 0 ? 32'h0000_0100 : 32'h0000_0777));
      end
      // Offset format wraps at the top of the range
      wr(8'h04, 32'h0000_FFF0);
      wr(8'h00, 32'h0000_0111);
      repeat (2) @(posedge clk_i);
      chk(32'(sp), 32'h0000_0010);
      wr(8'h00, 32'h0000_0102);
      repeat (2) @(posedge clk_i);
      tgain <= 32'h3333_3333;
      tdone <= 1'h1;
      @(posedge clk_i);
      tdone <= 1'h0;
      evt(1'h0);
      bus(1'h0, 8'h10, 32'h0000_0000, q);
      chk(q, 32'h3333_3333);
      bus(1'h0, 8'h0C, 32'h0000_0000, q);
      chk(q, 32'h1111_1111);
      // Tuning with the event released lands in the first gain set
      tgain <= 32'h4444_4444;
      tdone <= 1'h1;
      @(posedge clk_i);
      tdone <= 1'h0;
      bus(1'h0, 8'h0C, 32'h0000_0000, q);
      chk(q, 32'h4444_4444);
      bus(1'h0, 8'h10, 32'h0000_0000, q);
      chk(q, 32'h3333_3333);
      print_verdict();
   end
endmodule

// File: test/event_sel_chk.sv
`timescale 1ns/1ps
module event_sel_chk
   import event_sel_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        event_i,
   input wire logic        alarm1_o,
   input wire logic        alarm2_o,
   input wire logic        out1_inhibit_o,
   input wire logic        out2_inhibit_o,
   input wire logic        param_lock_o
);
   logic [3:0] fn_ff, nxt_fn;   // Select code as last accepted
   logic [2:0] age_ff, nxt_age; // Cycles since the code changed
   logic       ok;              // Code older than the event path
   // Mirror the select field; a write under lock is refused
   always_comb begin
      nxt_fn = fn_ff;
      if (ack_o && we_i && adr_i == 8'h00 && sel_i[0] && !param_lock_o) begin
         nxt_fn = dat_i[3:0];
      end
      nxt_age = age_ff;
      if (nxt_fn != fn_ff) begin
         nxt_age = 3'h0;
      end else if (age_ff != 3'h7) begin
         nxt_age = age_ff + 3'h1;
      end
   end
   // Register the mirror
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fn_ff  <= 4'h0;
         age_ff <= 3'h0;
      end else begin
         fn_ff  <= nxt_fn;
         age_ff <= nxt_age;
      end
   end
   // Mirror updates on the same edge as the block's register, so wait well past the 3-edge path
   assign ok = age_ff > 3'h4;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (
      ack_o |=> !ack_o) else $error("ack held past one cycle");
   inh_one_a: assert property (
      ok && fn_ff == FN_INH_O1 |-> out1_inhibit_o == $past(event_i, 3) && !out2_inhibit_o)
      else $error("output one inhibit wrong");
   inh_two_a: assert property (
      ok && fn_ff == FN_INH_O2 |-> out2_inhibit_o == $past(event_i, 3) && !out1_inhibit_o)
      else $error("output two inhibit wrong");
   inh_both_a: assert property (
      ok && fn_ff == FN_INH_BOTH |-> out1_inhibit_o == $past(event_i, 3) && out2_inhibit_o == $past(event_i, 3))
      else $error("dual inhibit wrong");
   lock_follow_a: assert property (
      ok && fn_ff == FN_LOCK |-> param_lock_o == $past(event_i, 3)) else $error("lock wrong");
   clr_one_a: assert property (
      ok && fn_ff == FN_CLR_A1 && $past(event_i, 3) |-> !alarm1_o) else $error("alarm one not cleared");
   clr_both_a: assert property (
      ok && fn_ff == FN_CLR_BOTH && $past(event_i, 3) |-> !alarm1_o && !alarm2_o)
      else $error("alarms not cleared");
   idle_fn_a: assert property (
      ok && (fn_ff == FN_NONE || fn_ff > 4'hA) |-> !out1_inhibit_o && !out2_inhibit_o && !param_lock_o)
      else $error("idle code acted");
endmodule
bind event_input_function_select event_sel_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .ack_o(ack_o), .event_i(event_i), .alarm1_o(alarm1_o), .alarm2_o(alarm2_o),
   .out1_inhibit_o(out1_inhibit_o), .out2_inhibit_o(out2_inhibit_o), .param_lock_o(param_lock_o));
